// ==== rtl/serial_port_defs.svh ====
// Constants for the multidrop serial port: offsets, fields, resets, timing.
// Assumes a 10 MHz system clock and a byte-addressed register port.
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH
`define CLK_HZ 10000000
`define BAUD_LO 19200
`define BAUD_MID 38400
`define BAUD_HI 57600
`define BIT_CYC_LO (`CLK_HZ / `BAUD_LO)
`define BIT_CYC_MID (`CLK_HZ / `BAUD_MID)
`define BIT_CYC_HI (`CLK_HZ / `BAUD_HI)
`define MS_PER_S 1000
`define MS_CYCLES (`CLK_HZ / `MS_PER_S)
`define GAP_BITS 16'h0024
`define DELAY_DEF_MS 7'h14
`define DELAY_MAX_MS 7'h63
`define BUF_BYTES 217
`define MAX_STATION 5'h1F
`define BCAST_ADDR 8'h00
`define CRC_POLY 16'hA001
`define CRC_INIT 16'hFFFF
// Register byte offsets and buffer select bit
`define OFF_CFG 11'h000
`define OFF_STATION 11'h004
`define OFF_DELAY 11'h008
`define OFF_STATUS 11'h00C
`define OFF_CMD 11'h010
`define OFF_LEN 11'h014
`define OFF_SLOPE 11'h018
`define OFF_OFFSET 11'h01C
`define BUF_SEL_BIT 10
// Field positions and reset values
`define CFG_BAUD 1:0
`define CFG_DATA8 2
`define CFG_STOP2 3
`define CFG_PAR 5:4
`define CFG_MODBUS 6
`define CFG_MODE 8:7
`define CFG_RESET 9'h004
`define CMD_SEND 0
`define CMD_RELEASE 1
`define CMD_CLRERR 2
`define SLOPE_RESET 16'h0100
`endif

// ==== rtl/serial_port_pkg.sv ====
// Types shared by the multidrop serial port modules.
// Assumes the constants header is compiled alongside.
package serial_port_pkg;
   typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_EVEN = 2'b01, PAR_ODD = 2'b10,
                             PAR_RSVD = 2'b11} parity_e;
   typedef enum logic [1:0] {MODE_SLAVE = 2'b00, MODE_PROGLESS = 2'b01,
                             MODE_PEER_MASTER = 2'b10, MODE_PEER_SLAVE = 2'b11} mode_e;
   typedef enum logic [4:0] {S_LISTEN = 5'b00001, S_RECV = 5'b00010, S_HOLD = 5'b00100,
                             S_WAIT = 5'b01000, S_SEND = 5'b10000} state_e;
endpackage : serial_port_pkg

// ==== rtl/char_rx.sv ====
// Start-stop character receiver, mid-bit sampling.
// Assumes rxd is synchronous to clk and idles high.
`timescale 1ns/1ps
`default_nettype none
module char_rx (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Line and format
   input wire logic rxd,
   input wire logic [9:0] bit_cyc,
   input wire logic data8,
   input wire serial_port_pkg::parity_e parity,
   // Character out
   output logic valid,
   output logic [7:0] data,
   output logic perr,
   output logic busy
);
   logic [9:0] cnt_reg;
   logic [3:0] pos_reg;
   logic [8:0] bits_reg;
   wire has_par = (parity == serial_port_pkg::PAR_EVEN) || (parity == serial_port_pkg::PAR_ODD);
   wire [3:0] last_pos = 4'h9 - {3'h0, ~data8} + {3'h0, has_par};
   wire par_bit = data8 ? bits_reg[8] : bits_reg[7];
   wire [7:0] word = data8 ? bits_reg[7:0] : {1'b0, bits_reg[6:0]};
   wire par_bad = has_par && ((^word ^ par_bit) != (parity == serial_port_pkg::PAR_ODD)); // RQ4

   ////////////////////////////////////////////////////////////////////////////
   // Bit sampler: start check, data and parity capture, stop check
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 10'h000;
         pos_reg <= 4'h0;
         bits_reg <= 9'h000;
         busy <= 1'b0;
         valid <= 1'b0;
         data <= 8'h00;
         perr <= 1'b0;
      end else begin
         valid <= 1'b0;
         if (!busy) begin
            if (!rxd) begin
               busy <= 1'b1;
               cnt_reg <= bit_cyc >> 1;
               pos_reg <= 4'h0;
            end
         end else if (cnt_reg != 10'h000) begin
            cnt_reg <= cnt_reg - 10'h001;
         end else begin
            cnt_reg <= bit_cyc - 10'h001;
            pos_reg <= pos_reg + 4'h1;
            if (pos_reg == 4'h0 && rxd) begin
               busy <= 1'b0; // False start
            end else if (pos_reg == last_pos) begin
               busy <= 1'b0;
               valid <= 1'b1;
               data <= word;
               perr <= par_bad | ~rxd; // Bad stop counts as an error
            end else if (pos_reg != 4'h0) begin
               bits_reg[pos_reg - 4'h1] <= rxd;
            end
         end
      end
   end
endmodule : char_rx
`default_nettype wire

// ==== rtl/char_tx.sv ====
// Start-stop character transmitter.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/1ps
`default_nettype none
module char_tx (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Format
   input wire logic [9:0] bit_cyc,
   input wire logic data8,
   input wire logic stop2,
   input wire serial_port_pkg::parity_e parity,
   // Character in
   input wire logic start,
   input wire logic [7:0] data,
   // Line out
   output logic txd,
   output logic busy
);
   logic [9:0] cnt_reg;
   logic [3:0] left_reg;
   logic [11:0] sh_reg;
   wire has_par = (parity == serial_port_pkg::PAR_EVEN) || (parity == serial_port_pkg::PAR_ODD);
   wire [7:0] word = data8 ? data : {1'b0, data[6:0]};
   wire par_bit = ^word ^ (parity == serial_port_pkg::PAR_ODD); // RQ4
   wire [8:0] body = data8 ? (has_par ? {par_bit, word} : {1'b1, word})
                           : (has_par ? {1'b1, par_bit, word[6:0]} : {2'b11, word[6:0]});
   wire [3:0] nbits = 4'h9 - {3'h0, ~data8} + {3'h0, has_par} + {3'h0, stop2};

   ////////////////////////////////////////////////////////////////////////////
   // Shifter: frame is start, data, parity, stop bits, sent LSB first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 10'h000;
         left_reg <= 4'h0;
         sh_reg <= 12'hFFF;
         txd <= 1'b1;
         busy <= 1'b0;
      end else if (!busy) begin
         txd <= 1'b1;
         if (start) begin
            busy <= 1'b1;
            sh_reg <= {2'b11, body, 1'b0};
            left_reg <= nbits;
            cnt_reg <= bit_cyc - 10'h001;
            txd <= 1'b0;
         end
      end else if (cnt_reg != 10'h000) begin
         cnt_reg <= cnt_reg - 10'h001;
      end else if (left_reg == 4'h0) begin
         busy <= 1'b0;
         txd <= 1'b1;
      end else begin
         cnt_reg <= bit_cyc - 10'h001;
         left_reg <= left_reg - 4'h1;
         sh_reg <= {1'b1, sh_reg[11:1]};
         txd <= sh_reg[1];
      end
   end
endmodule : char_tx
`default_nettype wire

// ==== rtl/multidrop_serial_comm_port.sv ====
// Half-duplex multidrop serial port: frame receive, check, hold, delayed reply.
// Assumes a 10 MHz clock, a plain register port, and an external line driver.
//
// How it works
// [RQ1] One talker at a time; driver enabled only sending.
// [RQ2] Rates 19200, 38400, 57600 bps, start-stop framing.
// [RQ3] Rate, width, stop bits, parity set independently.
// [RQ4] Parity none, even or odd, made and checked.
// [RQ5] Frame check BCC or CRC-16, generated and verified.
// [RQ6] Reply waits 0..99 ms delay, default 20.
// [RQ7] Programless mode: device starts its own PLC exchanges.
// [RQ8] Programless bus holds up to 32 controllers.
// [RQ9] Peer master copies parameters to slaves.
// [RQ10] Master broadcasts set point and run/stop.
// [RQ11] Slave scales received set point by slope, offset.
// [RQ12] Peer group at most 32 including master.
// [RQ13] No reply unless addressed; bad frames dropped.
// [RQ14] Characters beyond buffer capacity are discarded.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`include "serial_port_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module multidrop_serial_comm_port #(
   parameter int BUF_DEPTH = `BUF_BYTES,
   parameter int MS_CYCLES = `MS_CYCLES
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // Register port
   input wire logic [10:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // Bus line
   input wire logic LINE_IN,
   output logic LINE_OUT,
   output logic LINE_OE,
   // Peer set point
   output logic [15:0] SETPOINT,
   output logic RUN_CMD
);
   localparam int LW = $clog2(BUF_DEPTH + 1);

   // Register address match, used for both reads and writes
   function automatic logic hit(input logic [10:0] a, input logic [10:0] off);
      return (a == off);
   endfunction : hit

   // One byte of the reflected CRC-16
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_step

   ////////////////////////////////////////////////////////////////////////////
   // Registers and state
   serial_port_pkg::state_e state_reg, state_next;
   logic [8:0] cfg_reg;
   logic [4:0] station_reg;
   logic [6:0] delay_reg;
   logic [15:0] slope_reg, offset_reg;
   logic [LW-1:0] rx_len_reg, tx_len_reg, tx_pos_reg;
   logic [7:0] buf_mem [BUF_DEPTH];
   logic [15:0] rx_crc_reg, tx_crc_reg;
   logic [7:0] rx_bcc_reg, tx_bcc_reg;
   logic frame_err_reg, ready_reg, ovf_reg, perr_reg, chkerr_reg;
   logic [15:0] gap_reg;
   logic [$clog2(MS_CYCLES+1)-1:0] ms_reg;
   logic [6:0] dly_cnt_reg;
   logic tx_start_reg;
   logic [7:0] tx_byte_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration decode
   serial_port_pkg::parity_e parity;
   serial_port_pkg::mode_e mode;
   assign parity = serial_port_pkg::parity_e'(cfg_reg[`CFG_PAR]); // RQ3
   assign mode = serial_port_pkg::mode_e'(cfg_reg[`CFG_MODE]);
   wire modbus = cfg_reg[`CFG_MODBUS];
   wire [9:0] bit_cyc = (cfg_reg[`CFG_BAUD] == 2'b01) ? 10'(`BIT_CYC_MID) :
                        (cfg_reg[`CFG_BAUD] == 2'b10) ? 10'(`BIT_CYC_HI) :
                        10'(`BIT_CYC_LO); // RQ2 RQ3
   wire master_mode = (mode == serial_port_pkg::MODE_PROGLESS) ||
                      (mode == serial_port_pkg::MODE_PEER_MASTER); // RQ7 RQ9 RQ10
   wire [LW-1:0] chk_len = modbus ? LW'(2) : LW'(1);

   ////////////////////////////////////////////////////////////////////////////
   // Bus strobes
   wire wr_cfg = WR && hit(ADDR, `OFF_CFG);
   wire wr_cmd = WR && hit(ADDR, `OFF_CMD);
   wire cmd_send = wr_cmd && WDATA[`CMD_SEND];
   wire cmd_release = wr_cmd && WDATA[`CMD_RELEASE];
   wire cmd_clrerr = wr_cmd && WDATA[`CMD_CLRERR];
   wire buf_sel = ADDR[`BUF_SEL_BIT];
   wire [7:0] buf_idx = ADDR[9:2];
   wire buf_in = 32'(buf_idx) < BUF_DEPTH;
   wire buf_wr = WR && buf_sel && buf_in &&
                 (state_reg == serial_port_pkg::S_LISTEN || state_reg == serial_port_pkg::S_HOLD);

   ////////////////////////////////////////////////////////////////////////////
   // Character engines; receiver deaf while we drive the line
   logic rx_valid, rx_perr, rx_busy, tx_busy;
   logic [7:0] rx_data;
   char_rx u_rx (
      .clk(MCLK),
      .rst_n(RST_N),
      .rxd(LINE_IN | LINE_OE), // RQ1
      .bit_cyc(bit_cyc),
      .data8(cfg_reg[`CFG_DATA8]),
      .parity(parity),
      .valid(rx_valid),
      .data(rx_data),
      .perr(rx_perr),
      .busy(rx_busy)
   );
   char_tx u_tx (
      .clk(MCLK),
      .rst_n(RST_N),
      .bit_cyc(bit_cyc),
      .data8(cfg_reg[`CFG_DATA8]),
      .stop2(cfg_reg[`CFG_STOP2]),
      .parity(parity),
      .start(tx_start_reg),
      .data(tx_byte_reg),
      .txd(LINE_OUT),
      .busy(tx_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Frame acceptance
   wire rx_take = rx_valid && (state_reg == serial_port_pkg::S_LISTEN ||
                               state_reg == serial_port_pkg::S_RECV);
   wire rx_room = rx_len_reg < LW'(BUF_DEPTH);
   wire gap_done = (state_reg == serial_port_pkg::S_RECV) && !rx_busy &&
                   (gap_reg >= 16'(bit_cyc * `GAP_BITS));
   wire chk_ok = modbus ? (rx_crc_reg == 16'h0000 && rx_len_reg > LW'(2))
                        : (rx_bcc_reg == 8'h00 && rx_len_reg > LW'(1)); // RQ5
   wire addr_ok = (buf_mem[0] == {3'h0, station_reg}) || (buf_mem[0] == `BCAST_ADDR); // RQ13
   wire frame_good = gap_done && chk_ok && !frame_err_reg && addr_ok; // RQ13
   wire peer_take = frame_good && (mode == serial_port_pkg::MODE_PEER_SLAVE) &&
                    rx_len_reg > LW'(4); // RQ10
   wire [31:0] sp_prod = {buf_mem[1], buf_mem[2]} * slope_reg;
   wire [15:0] sp_scaled = sp_prod[23:8] + offset_reg; // RQ11

   ////////////////////////////////////////////////////////////////////////////
   // Transmit byte selection: buffer, then check bytes
   wire [LW-1:0] tx_total = tx_len_reg + chk_len;
   wire tx_from_buf = tx_pos_reg < tx_len_reg;
   wire [7:0] tx_sel = tx_from_buf ? buf_mem[tx_pos_reg] :
                       (tx_pos_reg == tx_len_reg) ? (modbus ? tx_crc_reg[7:0] : tx_bcc_reg) :
                       tx_crc_reg[15:8]; // RQ5
   wire tx_launch = (state_reg == serial_port_pkg::S_SEND) && !tx_start_reg && !tx_busy &&
                    (tx_pos_reg != tx_total);
   wire tx_done = (state_reg == serial_port_pkg::S_SEND) && !tx_start_reg && !tx_busy &&
                  (tx_pos_reg == tx_total);
   wire ms_tick = ms_reg == ($bits(ms_reg))'(MS_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         serial_port_pkg::S_LISTEN: begin
            if (rx_take) begin
               state_next = serial_port_pkg::S_RECV;
            end else if (cmd_send && master_mode) begin
               state_next = serial_port_pkg::S_SEND; // RQ7 RQ9 RQ10
            end
         end
         serial_port_pkg::S_RECV: begin
            if (frame_good) begin
               state_next = serial_port_pkg::S_HOLD;
            end else if (gap_done) begin
               state_next = serial_port_pkg::S_LISTEN; // RQ13
            end
         end
         serial_port_pkg::S_HOLD: begin
            if (cmd_send) begin
               state_next = serial_port_pkg::S_WAIT;
            end else if (cmd_release) begin
               state_next = serial_port_pkg::S_LISTEN;
            end
         end
         serial_port_pkg::S_WAIT: begin
            if (dly_cnt_reg == 7'h00) begin
               state_next = serial_port_pkg::S_SEND; // RQ6
            end
         end
         serial_port_pkg::S_SEND: begin
            if (tx_done) begin
               state_next = serial_port_pkg::S_LISTEN;
            end
         end
         default: state_next = serial_port_pkg::S_LISTEN;
      endcase
   end

   // State, line driver enable and response delay
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= serial_port_pkg::S_LISTEN;
         LINE_OE <= 1'b0;
         ms_reg <= '0;
         dly_cnt_reg <= 7'h00;
      end else begin
         state_reg <= state_next;
         LINE_OE <= state_next == serial_port_pkg::S_SEND; // RQ1 RQ13
         ms_reg <= (ms_tick || frame_good) ? '0 : ms_reg + 1'b1;
         if (frame_good) begin
            dly_cnt_reg <= delay_reg; // RQ6
         end else if (ms_tick && dly_cnt_reg != 7'h00) begin
            dly_cnt_reg <= dly_cnt_reg - 7'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive bookkeeping: length, running checks, gap timer
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rx_len_reg <= '0;
         rx_crc_reg <= `CRC_INIT;
         rx_bcc_reg <= 8'h00;
         frame_err_reg <= 1'b0;
         gap_reg <= 16'h0000;
      end else if (rx_take) begin
         gap_reg <= 16'h0000;
         if (state_reg == serial_port_pkg::S_LISTEN) begin
            rx_len_reg <= LW'(1);
            rx_crc_reg <= crc_step(`CRC_INIT, rx_data);
            rx_bcc_reg <= rx_data;
            frame_err_reg <= rx_perr; // RQ4
         end else begin
            frame_err_reg <= frame_err_reg | rx_perr | ~rx_room;
            if (rx_room) begin
               rx_len_reg <= rx_len_reg + 1'b1;
               rx_crc_reg <= crc_step(rx_crc_reg, rx_data);
               rx_bcc_reg <= rx_bcc_reg ^ rx_data;
            end
         end
      end else if (rx_busy) begin
         gap_reg <= 16'h0000;
      end else if (!gap_done) begin
         gap_reg <= gap_reg + 16'h0001;
      end
   end

   // Shared frame buffer: filled by the line, or by software for a reply
   always_ff @(posedge MCLK) begin
      if (rx_take && rx_room) begin
         buf_mem[(state_reg == serial_port_pkg::S_LISTEN) ? '0 : rx_len_reg] <= rx_data; // RQ14
      end else if (rx_take && state_reg == serial_port_pkg::S_LISTEN) begin
         buf_mem[0] <= rx_data; // First byte lands even after an overflowed frame
      end else if (buf_wr) begin
         buf_mem[buf_idx] <= WDATA[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit sequencing with appended check
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         tx_pos_reg <= '0;
         tx_crc_reg <= `CRC_INIT;
         tx_bcc_reg <= 8'h00;
         tx_start_reg <= 1'b0;
         tx_byte_reg <= 8'h00;
      end else begin
         tx_start_reg <= tx_launch;
         if (state_reg != serial_port_pkg::S_SEND) begin
            tx_pos_reg <= '0;
            tx_crc_reg <= `CRC_INIT;
            tx_bcc_reg <= 8'h00;
         end else if (tx_launch) begin
            tx_byte_reg <= tx_sel;
            tx_pos_reg <= tx_pos_reg + 1'b1;
            if (tx_from_buf) begin
               tx_crc_reg <= crc_step(tx_crc_reg, tx_sel); // RQ5
               tx_bcc_reg <= tx_bcc_reg ^ tx_sel;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers and sticky flags; a set beats a clear
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_reg <= `CFG_RESET;
         station_reg <= 5'h01;
         delay_reg <= `DELAY_DEF_MS;
         slope_reg <= `SLOPE_RESET;
         offset_reg <= 16'h0000;
         tx_len_reg <= '0;
         ready_reg <= 1'b0;
         ovf_reg <= 1'b0;
         perr_reg <= 1'b0;
         chkerr_reg <= 1'b0;
      end else begin
         if (wr_cfg) cfg_reg <= WDATA[8:0]; // RQ3
         if (WR && hit(ADDR, `OFF_STATION)) begin
            station_reg <= WDATA[4:0] & `MAX_STATION; // RQ8 RQ12
         end
         if (WR && hit(ADDR, `OFF_DELAY)) begin
            delay_reg <= (WDATA[6:0] > `DELAY_MAX_MS) ? `DELAY_MAX_MS : WDATA[6:0]; // RQ6
         end
         if (WR && hit(ADDR, `OFF_SLOPE)) slope_reg <= WDATA[15:0];
         if (WR && hit(ADDR, `OFF_OFFSET)) offset_reg <= WDATA[15:0];
         if (WR && hit(ADDR, `OFF_LEN)) begin
            tx_len_reg <= (WDATA[LW-1:0] > LW'(BUF_DEPTH)) ? LW'(BUF_DEPTH) : WDATA[LW-1:0];
         end
         ready_reg <= frame_good | (ready_reg & ~(cmd_send | cmd_release));
         ovf_reg <= (rx_take && !rx_room && state_reg == serial_port_pkg::S_RECV) |
                    (ovf_reg & ~cmd_clrerr); // RQ14
         perr_reg <= (rx_take && rx_perr) | (perr_reg & ~cmd_clrerr);
         chkerr_reg <= (gap_done && !chk_ok) | (chkerr_reg & ~cmd_clrerr);
      end
   end

   // Peer slave adopts the scaled set point and run/stop
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         SETPOINT <= 16'h0000;
         RUN_CMD <= 1'b0;
      end else if (peer_take) begin
         SETPOINT <= sp_scaled; // RQ10 RQ11
         RUN_CMD <= buf_mem[3][0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read selection, answered one cycle after the strobe
   wire [31:0] status_word = {22'h0, state_reg, tx_busy, chkerr_reg, perr_reg, ovf_reg, ready_reg};
   wire [31:0] buf_word = buf_in ? {24'h0, buf_mem[buf_idx]} : 32'h0;
   wire [31:0] rd_word = buf_sel ? buf_word :
                         hit(ADDR, `OFF_CFG) ? {23'h0, cfg_reg} :
                         hit(ADDR, `OFF_STATION) ? {27'h0, station_reg} :
                         hit(ADDR, `OFF_DELAY) ? {25'h0, delay_reg} :
                         hit(ADDR, `OFF_STATUS) ? status_word :
                         hit(ADDR, `OFF_LEN) ? {16'(tx_len_reg), 16'(rx_len_reg)} :
                         hit(ADDR, `OFF_SLOPE) ? {16'h0, slope_reg} :
                         hit(ADDR, `OFF_OFFSET) ? {16'h0, offset_reg} : 32'h0;
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= 32'h0;
      end else begin
         RDATA <= RD ? rd_word : 32'h0;
      end
   end
endmodule : multidrop_serial_comm_port
`default_nettype wire

// ==== testbench/serial_port_chk.sv ====
// Checker for the serial port: line driver, bit timing, read data, peer outputs.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module serial_port_chk (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // Register port
   input wire logic RD,
   input wire logic [31:0] RDATA,
   // Line and peer outputs
   input wire logic LINE_OUT,
   input wire logic LINE_OE,
   input wire logic [15:0] SETPOINT,
   input wire logic RUN_CMD
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   // Register port and line relations
   property p_rdata_idle; !RD |=> RDATA == 32'h0; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
   property p_line_idle; !LINE_OE |-> LINE_OUT; endproperty
   a_line_idle: assert property (p_line_idle) else $error("line low while released");
   property p_oe_rise; $rose(LINE_OE) |-> LINE_OUT ##1 LINE_OUT; endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("start bit too soon");
   property p_oe_hold; $rose(LINE_OE) |-> LINE_OE [*8]; endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("driver enable glitch");
   property p_low_hold; $fell(LINE_OUT) |-> !LINE_OUT [*8]; endproperty
   a_low_hold: assert property (p_low_hold) else $error("short low bit");
   property p_high_hold; LINE_OE && $rose(LINE_OUT) |-> LINE_OUT [*8]; endproperty
   a_high_hold: assert property (p_high_hold) else $error("short high bit");
   property p_oe_drop; $fell(LINE_OE) |-> LINE_OUT && $past(LINE_OUT, 4); endproperty
   a_oe_drop: assert property (p_oe_drop) else $error("driver off in mid bit");
   property p_peer_quiet; !$stable({SETPOINT, RUN_CMD}) |-> !LINE_OE; endproperty
   a_peer_quiet: assert property (p_peer_quiet) else $error("set point moved in send");
endmodule : serial_port_chk
bind multidrop_serial_comm_port serial_port_chk serial_port_chk_inst (.MCLK(MCLK),
   .RST_N(RST_N), .RD(RD), .RDATA(RDATA), .LINE_OUT(LINE_OUT), .LINE_OE(LINE_OE),
   .SETPOINT(SETPOINT), .RUN_CMD(RUN_CMD));
`default_nettype wire

// ==== testbench/serial_host.sv ====
// Host station model: sends even-parity 8-bit frames with BCC, receives replies.
// Assumes a biased bus that idles high and one stop bit.
`timescale 1ns/1ps
`default_nettype none
module serial_host #(
   parameter int BIT_CYC = 173
) (
   // Clock
   input wire logic clk,
   // Bus line
   input wire logic line_out,
   input wire logic line_oe,
   output var logic line_in
);
   initial line_in = 1'b1;
   // Frame with block check; bad flips one check bit
   task automatic send_frame(input logic [7:0] q[$], input logic bad);
      logic [7:0] bcc;
      logic [10:0] f;
      bcc = {7'h00, bad};
      foreach (q[k]) bcc ^= q[k];
      q.push_back(bcc);
      foreach (q[k]) begin
         f = {1'b1, ^q[k], q[k], 1'b0};
         for (int i = 0; i < 11; i++) begin
            @(posedge clk) line_in <= line_oe ? 1'b1 : f[i];
            repeat (BIT_CYC - 1) @(posedge clk);
         end
      end
   endtask : send_frame
   // Receive one character; ok low on timeout, parity or stop fault
   task automatic recv_byte(output logic [7:0] b, output logic ok);
      logic p;
      int n;
      b = 8'h00;
      n = 0;
      while (line_out !== 1'b0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge clk);
         b[i] = line_out;
      end
      repeat (BIT_CYC) @(posedge clk);
      p = line_out;
      repeat (BIT_CYC) @(posedge clk);
      ok = (n < 3000) && (p === ^b) && (line_out === 1'b1);
   endtask : recv_byte
endmodule : serial_host
`default_nettype wire

// ==== testbench/multidrop_serial_comm_port_tb.sv ====
// Testbench for the serial port: registers, bad and good frames, delayed reply.
// Assumes a 10 MHz clock and the millisecond count shortened to 10 cycles.
`timescale 1ns/1ps
`default_nettype none
module multidrop_serial_comm_port_tb;
   logic MCLK, RST_N, WR, RD, LINE_IN, LINE_OUT, LINE_OE, RUN_CMD, ok;
   logic [10:0] ADDR;
   logic [31:0] WDATA, RDATA, d;
   logic [15:0] SETPOINT;
   logic [7:0] b, rep[5] = '{8'h01, 8'h00, 8'h10, 8'h01, 8'h10};
   int fails, tests_run, n;
   multidrop_serial_comm_port #(.MS_CYCLES(10)) multidrop_serial_comm_port_inst (.MCLK(MCLK),
      .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .LINE_IN(LINE_IN), .LINE_OUT(LINE_OUT), .LINE_OE(LINE_OE), .SETPOINT(SETPOINT),
      .RUN_CMD(RUN_CMD));
   serial_host #(.BIT_CYC(173)) serial_host_inst (.clk(MCLK), .line_out(LINE_OUT),
      .line_oe(LINE_OE), .line_in(LINE_IN));
   initial begin
      MCLK = 1'b0;
      forever #50 MCLK = ~MCLK;
   end
   task automatic wr(input logic [10:0] a, input logic [31:0] v);
      @(posedge MCLK) begin ADDR <= a; WDATA <= v; WR <= 1'b1; end
      @(posedge MCLK) WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [10:0] a, output logic [31:0] v);
      @(posedge MCLK) begin ADDR <= a; RD <= 1'b1; end
      @(posedge MCLK) RD <= 1'b0;
      #1 v = RDATA;
   endtask : rd
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rchk(input string nm, input logic [10:0] a, input logic [31:0] e);
      rd(a, d);
      chk(nm, e, d);
   endtask : rchk
   task automatic close_out;
      $display("Counts: fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   // Reset values, clamping, unmapped place, then format set up
   task automatic t_regs;
      rchk("cfg", 11'h000, 32'h0000_0004);
      rchk("station", 11'h004, 32'h0000_0001);
      wr(11'h004, 32'h0000_00E1);
      rchk("stn mask", 11'h004, 32'h0000_0001);
      rchk("delay", 11'h008, 32'h0000_0014);
      rchk("slope", 11'h018, 32'h0000_0100);
      wr(11'h020, 32'hFFFF_FFFF);
      rchk("unmapped", 11'h020, 32'h0000_0000);
      wr(11'h008, 32'h0000_0078);
      rchk("delay clamp", 11'h008, 32'h0000_0063);
      wr(11'h000, 32'h0000_0196);
      rchk("cfg set", 11'h000, 32'h0000_0196);
      wr(11'h018, 32'h0000_0200);
      wr(11'h01C, 32'h0000_0005);
      wr(11'h008, 32'h0000_0002);
      wr(11'h014, 32'h0000_0004);
      $display("Test regs done");
   endtask : t_regs
   // Corrupted check: silent drop, check flag, back to listening
   task automatic t_bad;
      serial_host_inst.send_frame('{8'h01, 8'h05}, 1'b1);
      repeat (36 * 173 + 100) @(posedge MCLK);
      rd(11'h00C, d);
      chk("bad status", 32'h0000_0028, d & 32'h0000_03EF);
      wr(11'h010, 32'h0000_0004);
      $display("Test bad frame done");
   endtask : t_bad
   // Peer frame: scaled set point, run bit, delayed reply with check
   task automatic t_peer;
      serial_host_inst.send_frame('{8'h01, 8'h00, 8'h10, 8'h01}, 1'b0);
      for (n = 0; n < 8000 && d[0] !== 1'b1; n++) rd(11'h00C, d);
      chk("hold status", 32'h0000_0081, d & 32'h0000_03EF);
      chk("setpoint", 32'h0000_0025, {16'h0, SETPOINT});
      chk("run", 32'h1, {31'h0, RUN_CMD});
      wr(11'h010, 32'h0000_0001);
      for (n = 0; n < 100 && LINE_OE !== 1'b1; n++) @(posedge MCLK);
      chk("reply wait", 32'h1, {31'h0, n >= 8 && n <= 22});
      foreach (rep[k]) begin
         serial_host_inst.recv_byte(b, ok);
         chk("reply byte", {24'h0, rep[k]}, {24'h0, b});
         chk("reply frame", 32'h1, {31'h0, ok});
      end
      repeat (200) @(posedge MCLK);
      rchk("after reply", 11'h00C, 32'h0000_0020);
      $display("Test peer reply done");
   endtask : t_peer
   initial begin
      RST_N = 1'b0;
      WR = 1'b0;
      RD = 1'b0;
      ADDR = 11'h000;
      WDATA = 32'h0;
      repeat (8) @(posedge MCLK);
      RST_N <= 1'b1;
      t_regs();
      t_bad();
      t_peer();
      close_out();
   end
   initial begin
      repeat (100000) @(posedge MCLK);
      fails++;
      close_out();
   end
endmodule : multidrop_serial_comm_port_tb
`default_nettype wire
